// File: bench/msc_ifft_model.sv
// Purpose: downstream transform stage model taking mapped cells
// Assumes: out_valid holds until out_ready is seen high
// Notes: slow mode stalls every other cycle
`timescale 1ns/100ps
`default_nettype none

module msc_ifft_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic out_valid,
  input wire msc_pkg::msc_cell_out_t out_cell,
  output logic out_ready
);
  msc_pkg::msc_cell_out_t got [0:1023];
  int n;
  logic tog;

  // Stall pattern when slow
  assign out_ready = slow ? tog : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog <= 1'b0;
      n <= 0;
    end else begin
      tog <= ~tog;
      if (out_valid && out_ready) begin
        got[n] <= out_cell;
        n <= n + 1;
      end
    end
  end
endmodule

`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for the cell mapper
// Assumes: APB master on pclk, one cell offered at a time
// Notes: transform model stalls during the long symbol
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic in_valid, in_ready, out_valid, out_ready, slow, er;
  msc_pkg::msc_cell_in_t in_cell;
  msc_pkg::msc_cell_out_t out_cell;
  int num_errors, cmp_count, b;

  msc_cell_mapper uut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_cell(in_cell), .in_ready(in_ready),
    .out_valid(out_valid), .out_cell(out_cell), .out_ready(out_ready));
  msc_ifft_model ifm (.pclk(pclk), .presetn(presetn), .slow(slow),
    .out_valid(out_valid), .out_cell(out_cell), .out_ready(out_ready));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask

  // APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) begin
      num_errors++;
      $display("[FAIL] apb pready expected 1 seen timeout");
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic msc_pkg::msc_cell_out_t oc(input int k);
    return ifm.got[b + k];
  endfunction

  // One symbol of n cells, roles of first eight given as digits
  task automatic sym(input msc_pkg::msc_sym_t s, input logic odd,
                     input logic fs, input int n, input string r,
                     input logic [7:0] tp);
    int t;
    b = ifm.n;
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      in_valid <= 1'b1;
      in_cell <= '{sof: k == 0, frame_start: fs && k == 0, sym: s,
        sym_odd: odd, tr_partner: k < 8 && tp[k], re: 12'h064, im: 12'h000,
        role: k < 8 ? msc_pkg::msc_role_t'(3'(r[k]))
                    : msc_pkg::MSC_ROLE_DATA};
      t = 0;
      do begin
        @(posedge pclk);
        t++;
      end while (in_ready !== 1'b1 && t < 50);
      in_valid <= 1'b0;
      if (t >= 50) begin
        num_errors++;
        $display("[FAIL] in_ready expected 1 seen timeout");
      end
    end
    t = 0;
    while (ifm.n < b + n && t < 4000) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 4000) begin
      num_errors++;
      $display("[FAIL] out cells expected %0d seen %0d", b + n, ifm.n);
    end
  endtask

  task automatic t_regs();
    apb(1'b0, msc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, msc_pkg::ADDR_DX, 32'h0);
    chk("dx reset", 32'h3, rd);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk("unmapped err", 32'h1, er);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, msc_pkg::ADDR_CELLS, 32'h0);
    chk("cells reset", 32'h0, rd);
    apb(1'b1, msc_pkg::ADDR_ACE, 32'h5A3C0F21);
    apb(1'b0, msc_pkg::ADDR_ACE, 32'h0);
    chk("ace params", 32'h5A3C0F21, rd);
  endtask

  task automatic t_scat();
    string r;
    logic e;
    r = "10212000";
    apb(1'b1, msc_pkg::ADDR_CTRL, 32'h303);
    sym(msc_pkg::MSC_SYM_DATA, 1'b0, 1'b1, 8, r, 8'h00);
    for (int k = 0; k < 8; k++) begin
      e = (r[k] != "0") && ((k / 3) % 2 == 1);
      chk("pilot inv", e, oc(k).inverted);
    end
    chk("inv re", 32'hF9C, oc(3).re[11:0]);
    chk("k0 prbs", 32'h30, oc(0).prbs_idx);
    chk("k0 bin", 32'h12B0, oc(0).bin);
    chk("k5 carrier", 32'h5, oc(5).carrier);
  endtask

  task automatic t_close();
    for (int od = 0; od < 2; od++) begin
      sym(msc_pkg::MSC_SYM_FC, od[0], 1'b0, 4, "50050000", 8'h00);
      chk("fc k0 role", msc_pkg::MSC_ROLE_EDGE, oc(0).role);
      chk("fc k0 sym", msc_pkg::MSC_SYM_FC, oc(0).sym);
      chk("fc k0 inv", od, oc(0).inverted);
      chk("fc k3 inv", 32'h1, oc(3).inverted);
      chk("edge boost", msc_pkg::MSC_BOOST_SCAT, oc(0).boost);
    end
  endtask

  task automatic t_p2();
    sym(msc_pkg::MSC_SYM_P2, 1'b0, 1'b0, 8, "40040640", 8'h10);
    chk("pad k1", msc_pkg::MSC_ROLE_P2, oc(1).role);
    chk("pad k2", msc_pkg::MSC_ROLE_P2, oc(2).role);
    chk("p2 k3 inv", 32'h1, oc(3).inverted);
    chk("p2 k6 inv", 32'h0, oc(6).inverted);
    chk("tr partner", msc_pkg::MSC_ROLE_P2, oc(4).role);
    chk("p2 rsvd", msc_pkg::MSC_ROLE_RSVD, oc(5).role);
    chk("p2 rsvd re", 32'h0, oc(5).re[11:0]);
  endtask

  task automatic t_ext();
    for (int f = 0; f < 6; f++) begin
      apb(1'b1, msc_pkg::ADDR_CTRL, 32'h4 | (f << 8));
      sym(msc_pkg::MSC_SYM_DATA, 1'b0, 1'b1, 1, "00000000", 8'h00);
      apb(1'b0, msc_pkg::ADDR_STATUS, 32'h0);
      chk("ext status", f > 2 ? 32'h1 : 32'h2, rd & 32'h3);
    end
    apb(1'b1, msc_pkg::ADDR_CTRL, 32'h304);
    sym(msc_pkg::MSC_SYM_DATA, 1'b0, 1'b1, 49, "00000000", 8'h00);
    chk("ext k0 bin", 32'h1280, oc(0).bin);
    chk("ext k48 bin", 32'h12B0, oc(48).bin);
    chk("ext k48 prbs", 32'h30, oc(48).prbs_idx);
  endtask

  task automatic t_ace();
    logic [31:0] c;
    for (int i = 0; i < 3; i++) begin
      c = i == 0 ? 32'h310 : i == 1 ? 32'h318 : 32'h330;
      apb(1'b1, msc_pkg::ADDR_CTRL, c);
      sym(msc_pkg::MSC_SYM_DATA, 1'b0, 1'b1, 3, "10600000", 8'h00);
      apb(1'b0, msc_pkg::ADDR_STATUS, 32'h0);
      chk("ace status", {i == 2, i != 1}, (rd >> 2) & 32'h3);
      chk("ace data", i != 1, oc(1).ace_apply);
      chk("ace pilot", 32'h0, oc(0).ace_apply);
      chk("tr role", i == 2 ? msc_pkg::MSC_ROLE_RSVD
                            : msc_pkg::MSC_ROLE_DATA, oc(2).role);
      chk("tr re", i == 2 ? 32'h0 : 32'h64, oc(2).re[11:0]);
    end
  endtask

  task automatic t_p1();
    slow <= 1'b1;
    apb(1'b1, msc_pkg::ADDR_CTRL, 32'h0);
    sym(msc_pkg::MSC_SYM_P1, 1'b0, 1'b1, 427, "00000000", 8'h00);
    slow <= 1'b0;
    chk("p1 k0 bin", 32'h256, oc(0).bin);
    chk("p1 k426 bin", 32'h0, oc(426).bin);
    chk("p1 carrier", 32'h1AA, oc(426).carrier);
    apb(1'b0, msc_pkg::ADDR_CELLS, 32'h0);
    chk("cell count", 32'h203, rd);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    in_valid = 1'b0;
    in_cell = '0;
    slow = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_scat();
    t_close();
    t_p2();
    t_ext();
    t_ace();
    t_p1();
    print_verdict();
  end
endmodule

`default_nettype wire

// File: verilog/msc_cell_mapper.sv
// Purpose: frequency-domain cell mapper with MISO pilot handling
// Assumes: cells from the frame builder one per carrier, ascending
// Notes: APB slave, config taken at frame start, half-rate stream
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - group two inverts scattered, continual, closing pilots on odd Dx carriers
// - group two inverts P2 pilots on alternate multiples of P2 spacing
// - group two inverts edge pilots on alternate symbols
// - in the closing symbol the edge-pilot inversion wins
// - MISO P2 carriers between first normal and inverted pilot become pilots
// - MISO P2 partner of an unpaired reserved tone becomes a pilot
// - extended carriers only for 8K, 16K and 32K
// - extension count added on each side of the normal carriers
// - pilot PRBS indexed by physical carrier position
// - normal mode lowest carrier uses PRBS element at extension count
// - reserved tone cells are zeroed and carry no data
// - extended mode raises top index, centre stays at centre bin
// - P1 carrier 426 maps to the centre frequency bin
// - ACE disabled while rotated constellations are on
// - ACE touches only data cells
// - ACE and tone reservation enable independently
// - reserved tones in P2 kept whatever the peak reduction flag
// - closing pilots on Dx multiples, edge carriers carry edge pilots
// - edge pilots boosted like scattered pilots
module msc_cell_mapper (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [msc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire msc_pkg::msc_cell_in_t in_cell,
  output logic in_ready,
  output logic out_valid,
  output msc_pkg::msc_cell_out_t out_cell,
  input wire logic out_ready
);
  typedef struct packed {
    logic [msc_pkg::CTRL_W-1:0] ctrl;
    logic [msc_pkg::DXW-1:0] dx;
    logic [31:0] ace;
    logic [msc_pkg::CTRL_W-1:0] act;
    logic [msc_pkg::DXW-1:0] act_dx;
    logic ext_on;
    logic ext_ref;
    logic [15:0] cells;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic in_ready;
    logic out_valid;
    msc_pkg::msc_cell_out_t out;
  } msc_st_t;

  msc_st_t st_q;
  msc_st_t nx;
  logic acc;
  logic [msc_pkg::CTRL_W-1:0] cfg;
  logic [msc_pkg::DXW-1:0] cfg_dx;
  msc_pkg::msc_fft_t fft;
  logic miso, grp2, ext_ok, ext, p2_miso;
  logic [2:0] p2sp;
  logic [msc_pkg::KW-1:0] k, kx, ktot, kmax, kc, lo, hi;
  logic dx_hit, dx_odd, p2_odd;

  assign acc = ce && in_valid && st_q.in_ready;
  assign cfg = in_cell.frame_start ? st_q.ctrl : st_q.act;
  assign cfg_dx = in_cell.frame_start ? st_q.dx : st_q.act_dx;
  assign fft = msc_pkg::msc_fft_t'(cfg[msc_pkg::CTRL_FFT +: 3]);
  assign miso = cfg[msc_pkg::CTRL_MISO];
  assign grp2 = cfg[msc_pkg::CTRL_GRP2];
  assign ext_ok = fft inside {msc_pkg::MSC_FFT_8K, msc_pkg::MSC_FFT_16K,
                              msc_pkg::MSC_FFT_32K};
  assign ext = cfg[msc_pkg::CTRL_EXT] && ext_ok;
  assign p2sp = (miso || fft != msc_pkg::MSC_FFT_32K) ?
                msc_pkg::P2_SP_MISO : msc_pkg::P2_SP_WIDE;
  assign kx = msc_pkg::kext(fft);
  assign ktot = msc_pkg::ktot_norm(fft) + (ext ? (kx << 1) : '0);
  assign kmax = ktot - 1'b1;
  assign kc = kmax >> 1;
  assign lo = ext ? kx : '0;
  assign hi = lo + msc_pkg::ktot_norm(fft) - 1'b1;
  assign p2_miso = miso && in_cell.sym == msc_pkg::MSC_SYM_P2;

  msc_pos_track #(
    .KW(msc_pkg::KW),
    .DXW(msc_pkg::DXW)
  ) u_track (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .adv(acc),
    .sof(in_cell.sof),
    .dx(cfg_dx),
    .p2sp(p2sp),
    .k(k),
    .dx_hit(dx_hit),
    .dx_odd(dx_odd),
    .p2_odd(p2_odd)
  );

  always_comb begin
    msc_pkg::msc_role_t role;
    logic inv;
    logic hit;
    logic [31:0] rd;
    logic [31:0] stat;
    role = in_cell.role;
    inv = 1'b0;
    hit = 1'b1;
    rd = '0;
    stat = '0;
    nx = st_q;
    stat[msc_pkg::ST_EXT] = st_q.ext_on;
    stat[msc_pkg::ST_EXT_REF] = st_q.ext_ref;
    stat[msc_pkg::ST_ACE] = st_q.act[msc_pkg::CTRL_ACE] &&
                            !st_q.act[msc_pkg::CTRL_ROT];
    stat[msc_pkg::ST_TR] = st_q.act[msc_pkg::CTRL_TR];
    stat[msc_pkg::ST_MISO] = st_q.act[msc_pkg::CTRL_MISO];
    stat[msc_pkg::ST_OVALID] = st_q.out_valid;
    case (paddr)
      msc_pkg::ADDR_CTRL: rd[msc_pkg::CTRL_W-1:0] = st_q.ctrl;
      msc_pkg::ADDR_STATUS: rd = stat;
      msc_pkg::ADDR_DX: rd[msc_pkg::DXW-1:0] = st_q.dx;
      msc_pkg::ADDR_ACE: rd = st_q.ace;
      msc_pkg::ADDR_CELLS: rd[15:0] = st_q.cells;
      default: hit = 1'b0;
    endcase
    // Cell role adjustments
    if (in_cell.sym == msc_pkg::MSC_SYM_FC) begin
      if (k == '0 || k == kmax) begin
        role = msc_pkg::MSC_ROLE_EDGE;
      end else if (dx_hit) begin
        role = msc_pkg::MSC_ROLE_FC;
      end
    end
    if (p2_miso && (k == lo + 1'b1 || k == lo + 2'h2 ||
        k == hi - 2'h2 || k == hi - 1'b1)) begin
      role = msc_pkg::MSC_ROLE_P2;
    end
    if (p2_miso && role != msc_pkg::MSC_ROLE_RSVD && in_cell.tr_partner) begin
      role = msc_pkg::MSC_ROLE_P2;
    end
    if (role == msc_pkg::MSC_ROLE_RSVD && in_cell.sym != msc_pkg::MSC_SYM_P2 &&
        !cfg[msc_pkg::CTRL_TR]) begin
      role = msc_pkg::MSC_ROLE_DATA;
    end
    // Group two sign inversion
    if (miso && grp2) begin
      case (role)
        msc_pkg::MSC_ROLE_SCAT: inv = dx_odd;
        msc_pkg::MSC_ROLE_CONT: inv = dx_odd;
        msc_pkg::MSC_ROLE_FC: inv = dx_odd;
        msc_pkg::MSC_ROLE_P2: inv = p2_odd;
        msc_pkg::MSC_ROLE_EDGE: inv = in_cell.sym_odd;
        default: inv = 1'b0;
      endcase
    end
    if (ce) begin
      // APB slave
      nx.pready = 1'b0;
      nx.pslverr = 1'b0;
      if (psel && !penable) begin
        nx.pready = 1'b1;
        nx.pslverr = !hit;
        nx.prdata = hit ? rd : '0;
      end
      if (psel && penable && st_q.pready && pwrite && !st_q.pslverr) begin
        case (paddr)
          msc_pkg::ADDR_CTRL: nx.ctrl = pwdata[msc_pkg::CTRL_W-1:0];
          msc_pkg::ADDR_DX: nx.dx = pwdata[msc_pkg::DXW-1:0];
          msc_pkg::ADDR_ACE: nx.ace = pwdata;
          default: nx.ctrl = st_q.ctrl;
        endcase
      end
      // Cell stream
      if (st_q.out_valid && out_ready) begin
        nx.out_valid = 1'b0;
      end
      if (acc) begin
        if (in_cell.frame_start) begin
          nx.act = st_q.ctrl;
          nx.act_dx = st_q.dx;
          nx.ext_on = ext;
          nx.ext_ref = st_q.ctrl[msc_pkg::CTRL_EXT] && !ext_ok;
        end
        nx.out_valid = 1'b1;
        nx.cells = st_q.cells + 1'b1;
        nx.out.sym = in_cell.sym;
        nx.out.role = role;
        nx.out.inverted = inv;
        nx.out.carrier = k;
        nx.out.prbs_idx = k + (ext ? '0 : kx);
        if (in_cell.sym == msc_pkg::MSC_SYM_P1) begin
          nx.out.bin = (k - msc_pkg::P1_KC) & msc_pkg::P1_MASK;
        end else begin
          nx.out.bin = (k - kc) & msc_pkg::fft_mask(fft);
        end
        case (role)
          msc_pkg::MSC_ROLE_SCAT: nx.out.boost = msc_pkg::MSC_BOOST_SCAT;
          msc_pkg::MSC_ROLE_EDGE: nx.out.boost = msc_pkg::MSC_BOOST_SCAT;
          msc_pkg::MSC_ROLE_CONT: nx.out.boost = msc_pkg::MSC_BOOST_CONT;
          msc_pkg::MSC_ROLE_P2: nx.out.boost = msc_pkg::MSC_BOOST_P2;
          msc_pkg::MSC_ROLE_FC: nx.out.boost = msc_pkg::MSC_BOOST_FC;
          default: nx.out.boost = msc_pkg::MSC_BOOST_NONE;
        endcase
        // ACE and tone reservation are separate controls
        nx.out.ace_apply = cfg[msc_pkg::CTRL_ACE] && !cfg[msc_pkg::CTRL_ROT] &&
                           role == msc_pkg::MSC_ROLE_DATA;
        if (role == msc_pkg::MSC_ROLE_RSVD) begin
          nx.out.re = '0;
          nx.out.im = '0;
        end else begin
          nx.out.re = inv ? -in_cell.re : in_cell.re;
          nx.out.im = inv ? -in_cell.im : in_cell.im;
        end
      end
      nx.in_ready = !nx.out_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.ctrl <= msc_pkg::CTRL_RST;
      st_q.dx <= msc_pkg::DX_RST;
      st_q.act <= msc_pkg::CTRL_RST;
      st_q.act_dx <= msc_pkg::DX_RST;
    end else begin
      st_q <= nx;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign in_ready = st_q.in_ready;
  assign out_valid = st_q.out_valid;
  assign out_cell = st_q.out;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    ce && psel && !penable;
  endsequence
  sequence s_stall;
    out_valid && !out_ready;
  endsequence

  property p_apb_answer;
    s_setup |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer missing");

  property p_hold;
    s_stall |=> out_valid && $stable(out_cell);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output cell changed while stalled");

  property p_zero_rsvd;
    out_valid && out_cell.role == msc_pkg::MSC_ROLE_RSVD |->
      out_cell.re == '0 && out_cell.im == '0 && !out_cell.ace_apply;
  endproperty
  a_zero_rsvd: assert property (p_zero_rsvd)
    else $error("reserved cell not zero");

  property p_ace_data;
    out_valid && out_cell.ace_apply |-> out_cell.role == msc_pkg::MSC_ROLE_DATA;
  endproperty
  a_ace_data: assert property (p_ace_data)
    else $error("ace flag on a non-data cell");

  property p_ace_rot;
    acc && cfg[msc_pkg::CTRL_ROT] |=> !out_cell.ace_apply;
  endproperty
  a_ace_rot: assert property (p_ace_rot)
    else $error("ace active with rotation");

  property p_prbs;
    acc && !ext |=> out_cell.prbs_idx == out_cell.carrier + $past(kx);
  endproperty
  a_prbs: assert property (p_prbs)
    else $error("prbs offset wrong in normal mode");

  property p_edge_boost;
    out_valid && out_cell.role == msc_pkg::MSC_ROLE_EDGE |->
      out_cell.boost == msc_pkg::MSC_BOOST_SCAT;
  endproperty
  a_edge_boost: assert property (p_edge_boost)
    else $error("edge pilot boost wrong");

  property p_fc_edge;
    acc && in_cell.sym == msc_pkg::MSC_SYM_FC && k == '0 |=>
      out_cell.role == msc_pkg::MSC_ROLE_EDGE;
  endproperty
  a_fc_edge: assert property (p_fc_edge)
    else $error("closing symbol edge carrier not edge pilot");

  property p_inv_siso;
    acc && !(miso && grp2) |=> !out_cell.inverted;
  endproperty
  a_inv_siso: assert property (p_inv_siso)
    else $error("inversion outside group two");

  property p_p1_centre;
    acc && in_cell.sym == msc_pkg::MSC_SYM_P1 && k == msc_pkg::P1_KC |=>
      out_cell.bin == '0;
  endproperty
  a_p1_centre: assert property (p_p1_centre)
    else $error("p1 centre carrier off centre bin");

  property p_ext_ok;
    st_q.ext_on |-> st_q.act[msc_pkg::CTRL_FFT +: 3] >= 3'h3;
  endproperty
  a_ext_ok: assert property (p_ext_ok)
    else $error("extended mode on small fft");
endmodule

`default_nettype wire

// File: verilog/msc_pkg.sv
// Purpose: shared constants and types for the MISO pilot carrier mapper
// Assumes: APB register access, one cell per carrier
// Notes: register offsets are byte addresses

package msc_pkg;
  localparam int AW = 8;
  localparam int KW = 15;
  localparam int CELL_W = 12;
  localparam int DXW = 6;
  localparam int CTRL_W = 11;

  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AW-1:0] ADDR_DX = 8'h08;
  localparam logic [AW-1:0] ADDR_ACE = 8'h0C;
  localparam logic [AW-1:0] ADDR_CELLS = 8'h10;

  // Control fields
  localparam int CTRL_MISO = 0;
  localparam int CTRL_GRP2 = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_ROT = 3;
  localparam int CTRL_ACE = 4;
  localparam int CTRL_TR = 5;
  localparam int CTRL_FFT = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [DXW-1:0] DX_RST = 6'h03;

  // Status fields
  localparam int ST_EXT = 0;
  localparam int ST_EXT_REF = 1;
  localparam int ST_ACE = 2;
  localparam int ST_TR = 3;
  localparam int ST_MISO = 4;
  localparam int ST_OVALID = 5;

  localparam logic [2:0] P2_SP_MISO = 3'h3;
  localparam logic [2:0] P2_SP_WIDE = 3'h6;
  localparam logic [KW-1:0] P1_KC = 15'h01AA;
  localparam logic [KW-1:0] P1_MASK = 15'h03FF;

  typedef enum logic [2:0] {
    MSC_FFT_1K, MSC_FFT_2K, MSC_FFT_4K, MSC_FFT_8K, MSC_FFT_16K, MSC_FFT_32K
  } msc_fft_t;
  typedef enum logic [1:0] {
    MSC_SYM_P1, MSC_SYM_P2, MSC_SYM_DATA, MSC_SYM_FC
  } msc_sym_t;
  typedef enum logic [2:0] {
    MSC_ROLE_DATA, MSC_ROLE_SCAT, MSC_ROLE_CONT, MSC_ROLE_EDGE,
    MSC_ROLE_P2, MSC_ROLE_FC, MSC_ROLE_RSVD
  } msc_role_t;
  typedef enum logic [2:0] {
    MSC_BOOST_NONE, MSC_BOOST_SCAT, MSC_BOOST_CONT, MSC_BOOST_P2, MSC_BOOST_FC
  } msc_boost_t;

  typedef struct packed {
    logic sof;
    logic frame_start;
    msc_sym_t sym;
    logic sym_odd;
    msc_role_t role;
    logic tr_partner;
    logic signed [CELL_W-1:0] re;
    logic signed [CELL_W-1:0] im;
  } msc_cell_in_t;

  typedef struct packed {
    msc_sym_t sym;
    msc_role_t role;
    msc_boost_t boost;
    logic inverted;
    logic ace_apply;
    logic [KW-1:0] carrier;
    logic [KW-1:0] prbs_idx;
    logic [KW-1:0] bin;
    logic signed [CELL_W-1:0] re;
    logic signed [CELL_W-1:0] im;
  } msc_cell_out_t;

  function automatic logic [KW-1:0] ktot_norm(input msc_fft_t f);
    case (f)
      MSC_FFT_1K: ktot_norm = 15'h0355;
      MSC_FFT_2K: ktot_norm = 15'h06A9;
      MSC_FFT_4K: ktot_norm = 15'h0D51;
      MSC_FFT_8K: ktot_norm = 15'h1AA1;
      MSC_FFT_16K: ktot_norm = 15'h3541;
      default: ktot_norm = 15'h6A81;
    endcase
  endfunction

  function automatic logic [KW-1:0] kext(input msc_fft_t f);
    case (f)
      MSC_FFT_8K: kext = 15'h0030;
      MSC_FFT_16K: kext = 15'h0090;
      MSC_FFT_32K: kext = 15'h0120;
      default: kext = 15'h0000;
    endcase
  endfunction

  function automatic logic [KW-1:0] fft_mask(input msc_fft_t f);
    case (f)
      MSC_FFT_1K: fft_mask = 15'h03FF;
      MSC_FFT_2K: fft_mask = 15'h07FF;
      MSC_FFT_4K: fft_mask = 15'h0FFF;
      MSC_FFT_8K: fft_mask = 15'h1FFF;
      MSC_FFT_16K: fft_mask = 15'h3FFF;
      default: fft_mask = 15'h7FFF;
    endcase
  endfunction
endpackage

// File: verilog/msc_pos_track.sv
// Purpose: carrier position tracker for the cell mapper
// Assumes: one cell per carrier, ascending, first cell flagged by sof
// Notes: outputs describe the cell currently offered
`timescale 1ns/100ps
`default_nettype none

module msc_pos_track #(
  parameter int KW = msc_pkg::KW,
  parameter int DXW = msc_pkg::DXW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic adv,
  input wire logic sof,
  input wire logic [DXW-1:0] dx,
  input wire logic [2:0] p2sp,
  output logic [KW-1:0] k,
  output logic dx_hit,
  output logic dx_odd,
  output logic p2_odd
);
  typedef struct packed {
    logic [KW-1:0] k;
    logic [DXW-1:0] dxc;
    logic dxp;
    logic [2:0] p2c;
    logic p2p;
  } msc_trk_t;

  msc_trk_t st_q;
  msc_trk_t st_d;
  msc_trk_t cur;

  always_comb begin
    cur = sof ? '0 : st_q;
    st_d = st_q;
    if (ce && adv) begin
      st_d.k = cur.k + 1'b1;
      if (cur.dxc + 1'b1 == dx) begin
        st_d.dxc = '0;
        st_d.dxp = ~cur.dxp;
      end else begin
        st_d.dxc = cur.dxc + 1'b1;
        st_d.dxp = cur.dxp;
      end
      if (cur.p2c + 1'b1 == p2sp) begin
        st_d.p2c = '0;
        st_d.p2p = ~cur.p2p;
      end else begin
        st_d.p2c = cur.p2c + 1'b1;
        st_d.p2p = cur.p2p;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign k = cur.k;
  assign dx_hit = (cur.dxc == '0);
  assign dx_odd = cur.dxp;
  assign p2_odd = cur.p2p;
endmodule

`default_nettype wire
